/* File: sbfw_top.sv */
// serial boot sequencer: sync, baud change, write command, password,
// hex record intake with flash programming and sum return
// assumes byte-level uart outside; flash read data valid while memRdEn
`timescale 1ns/1ps
`default_nettype none
module sbfw_top #(
    parameter int REC_DEPTH = 32,
    parameter logic [8*sbfw_pkg::NUM_BAUD-1:0] BAUD_CODES =
        {8'h28, 8'h18, 8'h20, 8'h38, 8'h48}
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clkEn,
    // uart receive bytes
    input wire logic rxValid,
    input wire logic [7:0] rxData,
    input wire logic rxError,
    // uart transmit bytes
    output logic txValid,
    output logic [7:0] txData,
    input wire logic txReady,
    input wire logic txIdle,
    // rate control
    input wire logic [sbfw_pkg::NUM_BAUD-1:0] baudAllow,
    output logic [7:0] baudCode,
    output logic baudApply,
    // flash access
    output logic memRdEn,
    output logic [15:0] memRdAddr,
    input wire logic [7:0] memRdData,
    output logic progValid,
    output logic [15:0] progAddr,
    output logic [7:0] progData,
    // status
    input wire logic securityOn,
    output logic halted
);
    import sbfw_pkg::*;

    typedef struct packed {
        sbfw_state_e state;
        logic pushValid;
        logic [7:0] pushData;
        logic [7:0] idx;
        logic [3:0] errCnt;
        logic [7:0] errCode;
        logic [7:0] pendBaud;
        logic [7:0] baudCode;
        logic baudApply;
        logic [15:0] cntAddr;
        logic [15:0] cmpAddr;
        logic [7:0] pwLen;
        logic blank;
        logic [7:0] rxByte;
        logic [7:0] recLen;
        logic [15:0] recAddr;
        logic [7:0] recType;
        logic [7:0] recSum;
        logic [15:0] sum;
        logic rdEn;
        logic [15:0] rdAddr;
        logic progValid;
        logic [15:0] progAddr;
        logic [7:0] progData;
        logic halted;
    } sbfw_regs_s;

    // ***********************************************
    // reset release
    // ***********************************************
    logic rstMeta, rstn;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rstMeta <= 1'b0;
            rstn <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstn <= rstMeta;
        end
    end

    // ***********************************************
    // helpers
    // ***********************************************
    function automatic logic inArea(input logic [15:0] a);
        inArea = (a >= AREA_LO) && (a <= AREA_HI);
    endfunction

    function automatic logic baudOk(input logic [7:0] c,
                                    input logic [NUM_BAUD-1:0] allow);
        baudOk = 1'b0;
        for (int i = 0; i < NUM_BAUD; i++) begin
            if (allow[i] && BAUD_CODES[8*i +: 8] == c) begin
                baudOk = 1'b1;
            end
        end
    endfunction

    sbfw_stream_if #(.WIDTH(8)) txIn ();
    sbfw_stream_if #(.WIDTH(8)) txOut ();
    sbfw_tx_buf #(.WIDTH(8), .DEPTH(2)) txBuf (
        .clk(ref_clk),
        .rstn(rstn),
        .clkEn(clkEn),
        .inSide(txIn.snk),
        .outSide(txOut.src)
    );

    sbfw_regs_s st, n;
    logic [7:0] recBuf [REC_DEPTH];
    logic bufWe;
    logic [7:0] bufWa;
    logic [7:0] curByte;

    // ***********************************************
    // sequencer
    // ***********************************************
    always_comb begin
        n = st;
        n.pushValid = st.pushValid && !txIn.ready;
        n.rdEn = 1'b0;
        n.progValid = 1'b0;
        n.baudApply = 1'b0;
        bufWe = 1'b0;
        bufWa = st.idx - F_DATA;
        curByte = recBuf[st.idx[$clog2(REC_DEPTH)-1:0]];
        case (st.state)
            S_SYNC: begin
                // a garbled match byte is simply dropped
                if (rxValid && !rxError && rxData == MATCH_BYTE) begin
                    n.pushValid = 1'b1;
                    n.pushData = MATCH_BYTE;
                    n.state = S_BAUD;
                end
            end
            S_BAUD: if (rxValid) begin
                if (!rxError && baudOk(rxData, baudAllow)) begin
                    n.pushValid = 1'b1;
                    n.pushData = rxData;
                    n.pendBaud = rxData;
                    n.state = S_BAUD_DRAIN;
                end else begin
                    n.errCode = ERR_BAUD;
                    n.errCnt = '0;
                    n.state = S_ERR;
                end
            end
            S_BAUD_DRAIN: begin
                // rate flips only once the echo has fully left the line
                if (!st.pushValid && !txOut.valid && txIdle) begin
                    n.baudCode = st.pendBaud;
                    n.baudApply = 1'b1;
                    n.state = S_CMD;
                end
            end
            S_CMD: if (rxValid) begin
                if (rxError || rxData != CMD_WRITE) begin
                    n.errCode = ERR_CMD;
                    n.errCnt = '0;
                    n.state = S_ERR;
                end else if (securityOn) begin
                    n.state = S_HALT;
                end else begin
                    n.pushValid = 1'b1;
                    n.pushData = rxData;
                    n.idx = '0;
                    n.sum = '0;
                    n.blank = 1'b1;
                    n.state = S_BLANK_RD;
                end
            end
            S_BLANK_RD: begin
                n.rdEn = 1'b1;
                n.rdAddr = AREA_LO + {8'h00, st.idx};
                n.state = S_BLANK_CK;
            end
            S_BLANK_CK: begin
                if (memRdData != ERASED) begin
                    n.blank = 1'b0;
                end
                n.idx = st.idx + 1'b1;
                n.state = S_BLANK_RD;
                if (st.rdAddr == AREA_HI) begin
                    n.idx = '0;
                    n.state = S_ADDR;
                end
            end
            S_ADDR: if (rxValid) begin
                if (rxError) begin
                    n.state = S_HALT;
                end else begin
                    {n.cntAddr, n.cmpAddr} =
                        {st.cntAddr[7:0], st.cmpAddr, rxData};
                    n.idx = st.idx + 1'b1;
                    if (st.idx == ADDR_BYTES - 1'b1) begin
                        n.state = S_CNT_RD;
                    end
                end
            end
            S_CNT_RD: begin
                // both addresses must point into the protected area
                if (!inArea(st.cntAddr) || !inArea(st.cmpAddr)) begin
                    n.state = S_HALT;
                end else begin
                    n.rdEn = 1'b1;
                    n.rdAddr = st.cntAddr;
                    n.state = S_CNT_CK;
                end
            end
            S_CNT_CK: begin
                n.pwLen = memRdData;
                n.idx = '0;
                n.state = (st.blank || memRdData == '0) ? S_HEX : S_PW;
            end
            S_PW: if (rxValid) begin
                if (rxError) begin
                    n.state = S_HALT;
                end else begin
                    n.rxByte = rxData;
                    n.rdEn = 1'b1;
                    n.rdAddr = st.cmpAddr + {8'h00, st.idx};
                    n.state = S_PW_CK;
                end
            end
            S_PW_CK: begin
                n.idx = st.idx + 1'b1;
                if (memRdData != st.rxByte) begin
                    n.state = S_HALT;
                end else if (st.idx + 1'b1 == st.pwLen) begin
                    n.state = S_HEX;
                end else begin
                    n.state = S_PW;
                end
            end
            S_HEX: if (rxValid) begin
                if (rxError) begin
                    n.state = S_HALT;
                end else if (rxData == START_MARK) begin
                    n.idx = '0;
                    n.recSum = '0;
                    n.state = S_REC;
                end
            end
            S_REC: if (rxValid) begin
                n.recSum = st.recSum + rxData;
                n.idx = st.idx + 1'b1;
                if (rxError) begin
                    n.state = S_HALT;
                end else if (st.idx == F_LEN) begin
                    n.recLen = rxData;
                    // longer records than the buffer cannot be verified
                    if (rxData > 8'(REC_DEPTH)) begin
                        n.state = S_HALT;
                    end
                end else if (st.idx == F_AHI) begin
                    n.recAddr[15:8] = rxData;
                end else if (st.idx == F_ALO) begin
                    n.recAddr[7:0] = rxData;
                end else if (st.idx == F_TYPE) begin
                    n.recType = rxData;
                end else if (st.idx < F_DATA + st.recLen) begin
                    bufWe = 1'b1;
                end else if (st.recSum + rxData != '0) begin
                    n.state = S_HALT;
                end else if (st.recType == REC_DATA) begin
                    n.idx = '0;
                    n.state = (st.recLen == '0) ? S_HEX : S_PROG;
                end else if (st.recType == REC_END) begin
                    n.state = S_SUM_HI;
                end else begin
                    n.state = S_HALT;
                end
            end
            S_PROG: begin
                n.progValid = 1'b1;
                n.progAddr = st.recAddr + {8'h00, st.idx};
                n.progData = curByte;
                n.sum = st.sum + {8'h00, curByte};
                n.idx = st.idx + 1'b1;
                if (st.idx + 1'b1 == st.recLen) begin
                    n.state = S_HEX;
                end
            end
            S_SUM_HI: if (!st.pushValid) begin
                n.pushValid = 1'b1;
                n.pushData = st.sum[15:8];
                n.state = S_SUM_LO;
            end
            S_SUM_LO: if (!st.pushValid) begin
                n.pushValid = 1'b1;
                n.pushData = st.sum[7:0];
                n.state = S_CMD;
            end
            S_ERR: if (!st.pushValid) begin
                n.pushValid = 1'b1;
                n.pushData = (st.errCnt < ERR_REPEAT) ? ERR_LEAD1 :
                             (st.errCnt < ERR_REPEAT + ERR_REPEAT) ?
                             ERR_LEAD2 : st.errCode;
                n.errCnt = st.errCnt + 1'b1;
                if (st.errCnt == ERR_LEN - 1'b1) begin
                    n.state = S_HALT;
                end
            end
            S_HALT: n.state = S_HALT;
            default: n.state = S_HALT;
        endcase
        n.halted = (n.state == S_HALT);
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st <= '{state: S_SYNC, baudCode: BAUD_INIT, default: '0};
        end else if (clkEn) begin
            st <= n;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (clkEn && bufWe) begin
            recBuf[bufWa[$clog2(REC_DEPTH)-1:0]] <= rxData;
        end
    end

    assign txIn.valid = st.pushValid;
    assign txIn.data = st.pushData;
    assign txOut.ready = txReady;
    assign txValid = txOut.valid;
    assign txData = txOut.data;
    assign baudCode = st.baudCode;
    assign baudApply = st.baudApply;
    assign memRdEn = st.rdEn;
    assign memRdAddr = st.rdAddr;
    assign progValid = st.progValid;
    assign progAddr = st.progAddr;
    assign progData = st.progData;
    assign halted = st.halted;

    // ***********************************************
    // checks
    // ***********************************************
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn || !clkEn);

    match_echo_a: assert property (st.state == S_SYNC && rxValid
        && !rxError && rxData == MATCH_BYTE
        |=> st.pushValid && st.pushData == MATCH_BYTE && st.state == S_BAUD)
        else $error("match byte not echoed");
    baud_late_a: assert property ($changed(st.baudCode)
        |-> $past(st.state) == S_BAUD_DRAIN && !txValid && st.baudApply)
        else $error("rate changed before echo drained");
    err_seq_a: assert property (st.state == S_ERR && !st.pushValid
        && st.errCnt == ERR_REPEAT |=> st.pushData == ERR_LEAD2)
        else $error("error sequence out of order");
    cmd_echo_a: assert property (st.state == S_CMD && rxValid
        && !rxError && rxData == CMD_WRITE && !securityOn
        |=> st.pushValid && st.pushData == CMD_WRITE)
        else $error("write command not echoed");
    bad_cmd_a: assert property (st.state == S_CMD && rxValid
        && rxData != CMD_WRITE |=> st.state == S_ERR && st.errCode == ERR_CMD)
        else $error("bad command not reported");
    halt_stays_a: assert property (st.state == S_HALT
        |=> st.state == S_HALT && halted && !memRdEn && !progValid)
        else $error("left halt without reset");
    hex_quiet_a: assert property (st.state == S_HEX && rxValid
        && !rxError && rxData != START_MARK |=> st.state == S_HEX
        && !st.pushValid)
        else $error("hex phase reacted to non-mark byte");
    sum_order_a: assert property (st.state == S_SUM_HI && !st.pushValid
        |=> st.pushData == st.sum[15:8] ##1 st.state == S_SUM_LO [*1])
        else $error("sum upper byte not first");
    back_cmd_a: assert property (st.state == S_SUM_LO && !st.pushValid
        |=> st.state == S_CMD && $stable(st.baudCode))
        else $error("did not return to command wait");
    prog_src_a: assert property (progValid
        |-> $past(st.state) == S_PROG && $past(st.recType) == REC_DATA)
        else $error("programming outside data record");

    cover property (st.state == S_BAUD_DRAIN ##[1:1000] st.baudApply);
    cover property (st.state == S_PROG ##1 st.state == S_HEX);
    cover property (st.state == S_SUM_LO ##1 st.state == S_CMD);
    cover property (st.state == S_ERR ##[9:40] st.state == S_HALT);
endmodule
`default_nettype wire

/* File: sbfw_pkg.sv */
// constants and types for the serial boot flash write sequencer
// assumes a byte-level uart front end outside the block
`default_nettype none
package sbfw_pkg;
    // ***********************************************
    // protocol bytes
    // ***********************************************
    localparam logic [7:0] MATCH_BYTE = 8'h5a;
    localparam logic [7:0] BAUD_INIT = 8'h28;
    localparam logic [7:0] CMD_WRITE = 8'h30;
    localparam logic [7:0] ERR_LEAD1 = 8'ha1;
    localparam logic [7:0] ERR_LEAD2 = 8'ha3;
    localparam logic [7:0] ERR_BAUD = 8'h62;
    localparam logic [7:0] ERR_CMD = 8'h63;
    localparam logic [7:0] START_MARK = 8'h3a;
    localparam logic [7:0] ERASED = 8'hff;
    localparam logic [7:0] REC_DATA = 8'h00;
    localparam logic [7:0] REC_END = 8'h01;
    // ***********************************************
    // areas and counts
    // ***********************************************
    localparam logic [15:0] AREA_LO = 16'hffe0;
    localparam logic [15:0] AREA_HI = 16'hffff;
    localparam logic [3:0] ERR_REPEAT = 4'h3;
    localparam logic [3:0] ERR_LEN = 4'h9;
    localparam logic [7:0] ADDR_BYTES = 8'h04;
    localparam logic [7:0] F_LEN = 8'h00;
    localparam logic [7:0] F_AHI = 8'h01;
    localparam logic [7:0] F_ALO = 8'h02;
    localparam logic [7:0] F_TYPE = 8'h03;
    localparam logic [7:0] F_DATA = 8'h04;
    localparam int NUM_BAUD = 5;

    typedef enum logic [4:0] {
        S_SYNC, S_BAUD, S_BAUD_DRAIN, S_CMD, S_BLANK_RD, S_BLANK_CK,
        S_ADDR, S_CNT_RD, S_CNT_CK, S_PW, S_PW_CK, S_HEX, S_REC,
        S_PROG, S_SUM_HI, S_SUM_LO, S_ERR, S_HALT
    } sbfw_state_e;
endpackage
`default_nettype wire

/* File: sbfw_stream_if.sv */
// valid/ready byte stream between the sequencer and its tx buffer
// assumes both ends share one clock
`timescale 1ns/1ps
`default_nettype none
interface sbfw_stream_if #(parameter int WIDTH = 8);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src(output valid, output data, input ready);
    modport snk(input valid, input data, output ready);
endinterface
`default_nettype wire

/* File: sbfw_tx_buf.sv */
// small fifo in front of the uart transmitter
// assumes asynchronous active-low reset already released cleanly
`timescale 1ns/1ps
`default_nettype none
module sbfw_tx_buf #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    // clocking
    input wire logic clk,
    input wire logic rstn,
    input wire logic clkEn,
    // streams
    sbfw_stream_if.snk inSide,
    sbfw_stream_if.src outSide
);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    // entry 0 is always the head, so the output leaves straight from a flop
    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] next_mem [DEPTH];
    logic [CW-1:0] count, next_count, wrPos;
    logic headValid, next_headValid;
    logic doWr, doRd;

    always_comb begin
        doWr = inSide.valid && (count != FULL);
        doRd = outSide.ready && headValid;
        next_mem = mem;
        next_count = count;
        wrPos = doRd ? count - 1'b1 : count;
        if (doRd) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                next_mem[i] = mem[i + 1];
            end
        end
        for (int i = 0; i < DEPTH; i++) begin
            if (doWr && wrPos == CW'(i)) begin
                next_mem[i] = inSide.data;
            end
        end
        if (doWr && !doRd) begin
            next_count = count + 1'b1;
        end else if (doRd && !doWr) begin
            next_count = count - 1'b1;
        end
        next_headValid = (next_count != '0);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count <= '0;
            headValid <= 1'b0;
        end else if (clkEn) begin
            count <= next_count;
            headValid <= next_headValid;
        end
    end

    // storage holds no control state, so no reset needed
    always_ff @(posedge clk) begin
        if (clkEn) begin
            mem <= next_mem;
        end
    end

    assign inSide.ready = (count != FULL);
    assign outSide.valid = headValid;
    assign outSide.data = mem[0];
endmodule
`default_nettype wire

/* File: sbfw_uart_model.sv */
// uart transmit side model: takes bytes, with stalls and a busy gap
// assumes the bench supplies the stall pattern on one clock
`timescale 1ns/1ps
`default_nettype none
module sbfw_uart_model (
    // clocking
    input wire logic ref_clk,
    input wire logic resetn,
    // stall pattern
    input wire logic stall,
    // byte side
    input wire logic txValid,
    input wire logic [7:0] txData,
    output logic txReady,
    output logic txIdle,
    output logic gotValid,
    output logic [7:0] gotData
);
    // ***********************************************
    // shifter occupancy
    // ***********************************************
    logic [1:0] busy;
    // a taken byte keeps the shifter busy, so slow answers come from load
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            busy <= 2'h0;
        end else if (gotValid) begin
            busy <= 2'h3;
        end else if (busy != 2'h0) begin
            busy <= busy - 2'h1;
        end
    end
    assign txIdle = (busy == 2'h0);
    assign txReady = txIdle && !stall;
    assign gotValid = txValid && txReady;
    assign gotData = txData;
endmodule
`default_nettype wire

/* File: tb_serial_boot_flash_write_protocol.sv */
// bench for the serial boot sequencer: byte stimulus, flash model, queues
// assumes the tx model of sbfw_uart_model on the transmit side
`timescale 1ns/1ps
`default_nettype none
module tb_serial_boot_flash_write_protocol;
    import sbfw_pkg::*;
    logic ref_clk = 1'b0, resetn = 1'b0, rxValid = 1'b0, securityOn = 1'b0;
    logic stall = 1'b0, txValid, txReady, txIdle, gotValid, baudApply;
    logic memRdEn, progValid, halted;
    logic [7:0] rxData = 8'h00, txData, gotData, baudCode, progData;
    logic [7:0] memRdData;
    logic rxError = 1'b0, errByte = 1'b0;
    logic [15:0] memRdAddr, progAddr;
    logic [7:0] flash [65536];
    logic [7:0] outQ[$], expQ[$];
    logic [23:0] progQ[$], expProg[$];
    logic [31:0] rnd = 32'h0000_003b;
    int nFail = 0, nTests = 0, nApply = 0, nRead = 0;
    always #2.5 ref_clk = ~ref_clk;
    assign memRdData = flash[memRdAddr];
    sbfw_top i_sbfw_top (.ref_clk(ref_clk), .resetn(resetn), .clkEn(1'b1),
        .rxValid(rxValid), .rxData(rxData), .rxError(rxError),
        .txValid(txValid), .txData(txData), .txReady(txReady),
        .txIdle(txIdle), .baudAllow(5'h1e), .baudCode(baudCode),
        .baudApply(baudApply), .memRdEn(memRdEn), .memRdAddr(memRdAddr),
        .memRdData(memRdData), .progValid(progValid), .progAddr(progAddr),
        .progData(progData), .securityOn(securityOn), .halted(halted));
    sbfw_uart_model i_sbfw_uart_model (.ref_clk(ref_clk), .resetn(resetn),
        .stall(stall), .txValid(txValid), .txData(txData),
        .txReady(txReady), .txIdle(txIdle), .gotValid(gotValid),
        .gotData(gotData));
    // ***********************************************
    // helpers
    // ***********************************************
    function automatic logic [31:0] xs();
        rnd ^= rnd << 13;
        rnd ^= rnd >> 17;
        rnd ^= rnd << 5;
        return rnd;
    endfunction
    always @(posedge ref_clk) begin
        if (gotValid) outQ.push_back(gotData);
        if (progValid) progQ.push_back({progAddr, progData});
        if (baudApply) nApply++;
        if (memRdEn) nRead++;
        stall <= 1'(xs());
    end
    task automatic check(input logic [23:0] seen, input logic [23:0] want);
        nTests++;
        if (seen !== want) begin
            nFail++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic giveVerdict();
        if (nFail == 0 && nTests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // spacing keeps every byte clear of the longest internal-only state
    task automatic send(input logic [7:0] b);
        @(posedge ref_clk);
        rxValid <= 1'b1;
        rxData <= b;
        rxError <= errByte;
        @(posedge ref_clk);
        rxValid <= 1'b0;
        rxError <= 1'b0;
        repeat (110) @(posedge ref_clk);
    endtask
    task automatic doReset();
        @(posedge ref_clk);
        resetn <= 1'b0;
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check(24'(halted), 24'h0);
        nApply = 0;
        nRead = 0;
        outQ.delete();
        expQ.delete();
        progQ.delete();
        expProg.delete();
    endtask
    task automatic checkOut(input logic wantHalt);
        repeat (200) @(posedge ref_clk);
        check(24'(outQ.size()), 24'(expQ.size()));
        foreach (expQ[i]) check(24'(outQ[i]), 24'(expQ[i]));
        check(24'(progQ.size()), 24'(expProg.size()));
        foreach (expProg[i]) check(progQ[i], expProg[i]);
        check(24'(halted), 24'(wantHalt));
    endtask
    task automatic sendAll(input logic [7:0] b []);
        foreach (b[i]) send(b[i]);
    endtask
    // ***********************************************
    // scenarios
    // ***********************************************
    initial begin
        logic [7:0] d0, d1, alo;
        int sum;
        foreach (flash[i]) flash[i] = 8'hff;
        doReset();
        sendAll('{8'h00, MATCH_BYTE, 8'h18, CMD_WRITE});
        expQ = '{MATCH_BYTE, 8'h18, CMD_WRITE};
        sendAll('{8'hff, 8'he0, 8'hff, 8'he1, 8'h55, START_MARK});
        d0 = 8'(xs());
        d1 = 8'(xs());
        alo = 8'(xs());
        sendAll('{8'h02, 8'h10, alo, REC_DATA, d0, d1});
        send(8'(0 - (2 + 16 + alo + d0 + d1)));
        expProg = '{{8'h10, alo, d0}, {16'(16'h1000 + alo + 1), d1}};
        sum = d0 + d1;
        sendAll('{START_MARK, 8'h00, 8'h00, 8'h00, REC_END, 8'hff});
        expQ.push_back(8'(sum >> 8));
        expQ.push_back(8'(sum));
        send(CMD_WRITE);
        expQ.push_back(CMD_WRITE);
        checkOut(1'b0);
        check(24'(baudCode), 24'h18);
        check(24'(nApply), 24'h1);
        check(24'(nRead), 24'h41);
        check(24'(memRdAddr), 24'h00_ffff);
        for (int k = 0; k < 7; k++) begin
            doReset();
            securityOn <= (k == 2);
            if (k >= 3) begin
                {flash[16'hffe0], flash[16'hffe1]} =
                    (k == 4) ? 16'hffff : 16'h0211;
            end
            sendAll('{MATCH_BYTE, (k == 0) ? 8'h48 : BAUD_INIT});
            expQ = '{MATCH_BYTE};
            if (k != 0) expQ.push_back(BAUD_INIT);
            if (k != 0) send((k == 1) ? 8'h31 : CMD_WRITE);
            if (k > 2) expQ.push_back(CMD_WRITE);
            if (k == 3) sendAll('{8'hff, 8'he0, 8'hff, 8'he1, 8'h12, 8'h33});
            if (k == 4) sendAll('{8'h10, 8'h00, 8'hff, 8'he1});
            // right password, then an empty end record returns a zero sum
            if (k == 5) begin
                sendAll('{8'hff, 8'he0, 8'hff, 8'he1, 8'h11, 8'hff});
                sendAll('{START_MARK, 8'h00, 8'h00, 8'h00, REC_END, 8'hff});
                expQ.push_back(8'h00);
                expQ.push_back(8'h00);
            end
            // receive error on the first address byte
            if (k == 6) begin
                errByte = 1'b1;
                send(8'hff);
                errByte = 1'b0;
            end
            for (int j = 0; j < 9 && k < 2; j++) begin
                expQ.push_back(j < 3 ? ERR_LEAD1 : j < 6 ? ERR_LEAD2 :
                    k == 0 ? ERR_BAUD : ERR_CMD);
            end
            checkOut(k != 5);
        end
        giveVerdict();
    end
    initial begin
        repeat (40000) @(posedge ref_clk);
        nFail++;
        giveVerdict();
    end
endmodule
`default_nettype wire
